// >>> autoneg_partner_pkg.sv
// Functional notes
// - base bit 15: partner wants next pages
// - base bit 14: partner acknowledged FLP bursts
// - base bit 13: partner reports fault
// - base bits 12:5: partner technology abilities
// - base bits 4:0: partner selector code
// - next-page bit 15: more pages follow
// - next-page bit 14: partner acknowledged code word
// - next-page bit 13: message versus unformatted page
// - next-page bit 12: partner can comply
// - next-page bit 11: partner sync toggle
// - next-page bits 10:0: 11-bit code field
// - expansion bit 4 latches parallel detection fault
// - fault flag clears only on expansion read
// - expansion bit 3: partner next-page capable
// - expansion bit 2 always reads one
// - expansion bit 1 latches on next page received
// - expansion bit 0: partner negotiation capable
// - contents valid once complete; restart clears page words and expansion bit 3
// - technology bit 8 is 100BASE-TX full duplex
package autoneg_partner_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] partner_ability_addr   = 5'h05;
  localparam logic [4:0] expansion_status_addr  = 5'h06;

  // ----------------------------------------------------------------
  // partner ability fields
  // ----------------------------------------------------------------
  localparam int partner_more_pages_bit        = 15;
  localparam int partner_acknowledge_bit       = 14;
  localparam int partner_fault_flag_bit        = 13;
  localparam int partner_technology_msb        = 12;
  localparam int partner_technology_lsb        = 5;
  localparam int partner_selector_msb          = 4;
  localparam int partner_selector_lsb          = 0;
  localparam int partner_message_page_bit      = 13;
  localparam int partner_comply_bit            = 12;
  localparam int partner_sync_toggle_bit       = 11;
  localparam int page_code_msb                 = 10;
  localparam int page_code_lsb                 = 0;
  localparam logic [4:0] ieee_selector_code    = 5'h01;

  // technology ability bit positions within the 16-bit word
  localparam int tech_100tx_full_bit           = 8;
  localparam int tech_100tx_bit                = 7;
  localparam int tech_10t_full_bit             = 6;
  localparam int tech_10t_bit                  = 5;

  // ----------------------------------------------------------------
  // expansion fields
  // ----------------------------------------------------------------
  localparam int parallel_detection_fault_bit  = 4;
  localparam int partner_extra_page_bit        = 3;
  localparam int local_next_page_bit           = 2;
  localparam int page_received_bit             = 1;
  localparam int partner_negotiation_bit       = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] page_word_reset      = 16'h0000;
  localparam logic [15:0] read_data_reset      = 16'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  addr;
  } mgmt_req_s;

  typedef struct packed {
    logic        base_page_valid;
    logic        next_page_valid;
    logic [15:0] page_word;
    logic        parallel_fault_event;
    logic        partner_negotiation_capable;
    logic        negotiation_complete;
    logic        negotiation_restart;
  } arb_event_s;

  typedef struct packed {
    logic [15:0] base_word;
    logic [15:0] next_word;
    logic        view_next;
    logic        parallel_detection_fault;
    logic        page_received_flag;
    logic        partner_extra_page_capable;
    logic [15:0] read_data;
    logic        read_valid;
  } regs_state_s;

endpackage : autoneg_partner_pkg

// >>> autoneg_partner_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module autoneg_partner_status_regs
  import autoneg_partner_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // management interface
  input  wire mgmt_req_s   mgmt_req,
  output logic [15:0]      read_data,
  output logic             read_valid,
  // arbitration side
  input  wire arb_event_s  arb_event,
  // status
  output logic             contents_valid,
  output logic             partner_100tx_full
);

  regs_state_s state;
  regs_state_s next_state;

  logic [15:0] ability_view;
  logic [15:0] expansion_view;
  logic        expansion_read;

  // ----------------------------------------------------------------
  // read views
  // ----------------------------------------------------------------
  always_comb begin
    ability_view = state.view_next ? state.next_word : state.base_word;

    expansion_view = 16'h0000;
    expansion_view[parallel_detection_fault_bit] = state.parallel_detection_fault;
    expansion_view[partner_extra_page_bit] = state.partner_extra_page_capable;
    expansion_view[local_next_page_bit] = 1'b1;
    expansion_view[page_received_bit] = state.page_received_flag;
    expansion_view[partner_negotiation_bit] = arb_event.partner_negotiation_capable;
  end

  assign expansion_read = mgmt_req.read && (mgmt_req.addr == expansion_status_addr);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.read_valid = mgmt_req.read;

    if (mgmt_req.read) begin
      case (mgmt_req.addr)
        partner_ability_addr: begin
          next_state.read_data = ability_view;
        end
        expansion_status_addr: begin
          next_state.read_data = expansion_view;
        end
        default: begin
          next_state.read_data = read_data_reset;
        end
      endcase
    end

    if (expansion_read) begin
      next_state.parallel_detection_fault = 1'b0;
    end
    if (expansion_read) begin
      next_state.page_received_flag = 1'b0;
    end

    if (arb_event.parallel_fault_event) begin
      next_state.parallel_detection_fault = 1'b1;
    end

    if (arb_event.base_page_valid) begin
      next_state.base_word = arb_event.page_word;
      next_state.view_next = 1'b0;
      next_state.partner_extra_page_capable = arb_event.page_word[partner_more_pages_bit];
    end

    if (arb_event.next_page_valid) begin
      next_state.next_word = arb_event.page_word;
      next_state.view_next = 1'b1;
      next_state.page_received_flag = 1'b1;
    end

    if (arb_event.negotiation_restart) begin
      next_state.base_word = page_word_reset;
      next_state.next_word = page_word_reset;
      next_state.view_next = 1'b0;
      next_state.partner_extra_page_capable = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{base_word: page_word_reset, next_word: page_word_reset, view_next: 1'b0,
                 parallel_detection_fault: 1'b0, page_received_flag: 1'b0,
                 partner_extra_page_capable: 1'b0, read_data: read_data_reset,
                 read_valid: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign read_data          = state.read_data;
  assign read_valid         = state.read_valid;
  assign contents_valid     = arb_event.negotiation_complete;
  assign partner_100tx_full = state.base_word[tech_100tx_full_bit];

endmodule // autoneg_partner_status_regs
`default_nettype wire

// >>> autoneg_partner_status_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module autoneg_partner_status_regs_monitor
  import autoneg_partner_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire mgmt_req_s   mgmt_req,
  input wire logic [15:0] read_data,
  input wire arb_event_s  arb_event,
  input wire logic        contents_valid,
  input wire logic        partner_100tx_full
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic rd5 = mgmt_req.read && mgmt_req.addr == partner_ability_addr;
  wire logic rd6 = mgmt_req.read && mgmt_req.addr == expansion_status_addr;
  wire logic pf = arb_event.parallel_fault_event;
  wire logic np = arb_event.next_page_valid;
  wire logic rs = arb_event.negotiation_restart;
  wire logic nb = arb_event.base_page_valid && !np && !rs;
  a_fixed_bits: assert property (
    rd6 |=> read_data[2] && read_data[15:5] == 11'h0) else $error("fixed bits");
  a_fault_set: assert property (
    pf ##1 rd6 |=> read_data[4]) else $error("fault unset");
  a_fault_clear: assert property (
    rd6 && !pf ##1 rd6 && !pf |=> !read_data[4]) else $error("fault kept");
  a_page_set: assert property (
    np ##1 !rd6 ##1 rd6 |=> read_data[1]) else $error("page flag unset");
  a_next_view: assert property (
    np && !rs ##1 rd5 |=> read_data == $past(arb_event.page_word, 2)) else $error("next view");
  a_restart_view: assert property (
    rs ##1 rd5 |=> read_data == 16'h0000) else $error("restart view");
  a_base_view: assert property (
    nb ##1 rd5 |=> read_data == $past(arb_event.page_word, 2)) else $error("base view");
  a_valid_copy: assert property (
    contents_valid == arb_event.negotiation_complete) else $error("valid copy");
  a_tx_full: assert property (
    nb |=> partner_100tx_full == $past(arb_event.page_word[8])) else $error("tx full");
endmodule // autoneg_partner_status_regs_monitor
`default_nettype wire

// >>> link_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
module link_partner_model
  import autoneg_partner_pkg::*;
(
  input  wire logic       clock,
  output wire arb_event_s arb_event
);
  logic [3:0]  k = 4'h0;
  logic [15:0] w = 16'h0;
  logic        cap = 1'h0;
  logic        done = 1'h0;
  assign arb_event = '{k[3], k[2], w, k[1], cap, done, k[0]};
  // one word or event for a cycle, then the word line drifts
  task automatic send(input logic [3:0] tk, input logic [15:0] tw);
    @(negedge clock);
    {k, w} = {tk, tw};
    @(negedge clock);
    {k, w} = {4'h0, ~tw};
  endtask
endmodule // link_partner_model
`default_nettype wire

// >>> autoneg_partner_status_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module autoneg_partner_status_regs_tb_top;
  import autoneg_partner_pkg::*;
  logic        clock = 1'h0;
  logic        rst_n = 1'h0;
  mgmt_req_s   mgmt_req = '0;
  logic [15:0] read_data, pw;
  logic        read_valid, contents_valid, partner_100tx_full;
  arb_event_s  arb_event;
  logic [31:0] notes[$];
  logic [31:0] nt;
  int          n_fail = 0, check_count = 0, cyc = 0;
  always #2 clock = ~clock;
  autoneg_partner_status_regs DUT (.clock(clock), .rst_n(rst_n), .mgmt_req(mgmt_req),
    .read_data(read_data), .read_valid(read_valid), .arb_event(arb_event),
    .contents_valid(contents_valid), .partner_100tx_full(partner_100tx_full));
  link_partner_model partner (.clock(clock), .arb_event(arb_event));
  task automatic chk(input string s, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask
  // one request; m selects the judged bits
  task automatic acc(input logic rd, wr, input logic [4:0] a, input logic [15:0] m, e,
                     input bit last);
    @(negedge clock);
    mgmt_req = '{rd, wr, a};
    if (rd) notes.push_back({m, e & m});
    if (last) begin
      @(negedge clock);
      mgmt_req = '0;
    end
  endtask
  // the page or event lands at one edge; the read goes out one cycle later
  task automatic ev_rd(input logic [3:0] k, input logic [15:0] w, input logic [4:0] a,
                       input logic [15:0] e);
    fork
      partner.send(k, w);
      begin
        @(negedge clock);
        acc(1'h1, 1'h0, a, 16'hffff, e, 1'h0);
      end
    join
  endtask
  always @(negedge clock) if (read_valid === 1'h1) begin
    nt = notes.pop_front();
    chk("read_data", nt[15:0], read_data & nt[31:16]);
  end
  task automatic close_out;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      close_out;
    end
  end
  initial begin
    void'($urandom(32'hd389));
    repeat (4) @(negedge clock);
    rst_n = 1'h1;
    acc(1'h1, 1'h0, 5'h6, 16'hffff, 16'h0004, 1'h1);
    acc(1'h1, 1'h0, 5'h7, 16'hffff, 16'h0000, 1'h1);
    $display("test reset done");
    pw = 16'($urandom) | 16'h8000;
    partner.cap = 1'h1;
    partner.done = 1'h1;
    @(negedge clock);
    ev_rd(4'h8, pw, 5'h5, pw);
    chk("tx_full", {15'h0, pw[8]}, {15'h0, partner_100tx_full});
    chk("valid", 16'h1, {15'h0, contents_valid});
    acc(1'h1, 1'h0, 5'h6, 16'hfffd, 16'h000d, 1'h1);
    $display("test base done");
    for (int i = 0; i < 4; i++) begin
      pw = 16'($urandom);
      ev_rd(4'h4, pw, 5'h5, pw);
      acc(1'h1, 1'h0, 5'h6, 16'hffff, 16'h000f, 1'h0);
      acc(1'h1, 1'h0, 5'h6, 16'hffff, 16'h000d, 1'h1);
    end
    $display("test pages done");
    partner.send(4'h2, 16'h0);
    acc(1'h0, 1'h1, 5'h6, 16'h0, 16'h0, 1'h0);
    acc(1'h1, 1'h0, 5'h6, 16'h0010, 16'h0010, 1'h0);
    fork
      acc(1'h1, 1'h0, 5'h6, 16'h0010, 16'h0000, 1'h0);
      partner.send(4'h2, 16'h0);
    join_any
    acc(1'h1, 1'h0, 5'h6, 16'h0010, 16'h0010, 1'h1);
    $display("test fault done");
    ev_rd(4'h1, 16'h0, 5'h5, 16'h0);
    acc(1'h1, 1'h0, 5'h6, 16'hffed, 16'h0005, 1'h1);
    partner.done = 1'h0;
    #1 chk("valid", 16'h0, {15'h0, contents_valid});
    $display("test restart done");
    repeat (3) @(negedge clock);
    close_out;
  end
endmodule // autoneg_partner_status_regs_tb_top
bind autoneg_partner_status_regs autoneg_partner_status_regs_monitor mon (.clock(clock),
  .rst_n(rst_n), .mgmt_req(mgmt_req), .read_data(read_data), .arb_event(arb_event),
  .contents_valid(contents_valid), .partner_100tx_full(partner_100tx_full));
`default_nettype wire
